// [core/adc_serial_port_power_ctrl.sv]
// serial register port, clocking, gp outputs, bias enables and power sequencing
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_defines.svh"

module adc_serial_port_power_ctrl
   import adc_port_pkg::*;
#(
   parameter int unsigned PD_WAKE_CYCLES = `PD_WAKE_CYC,
   parameter int unsigned OSC_WAKE_CYCLES = `OSC_WAKE_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic        cs_n,
   input  wire logic        sclk,
   input  wire logic        din,
   output logic             dout_rdy,
   output logic             dout_rdy_oe,
   input  wire logic        conv_valid,
   input  wire logic [23:0] conv_data,
   input  wire logic        ext_clk_in,
   output logic             clk_pin_out,
   output logic             clk_pin_oe,
   output logic             mclk_tick,
   output logic             gp_out_pin_a,
   output logic             gp_out_pin_a_oe,
   output logic             gp_out_pin_b,
   output logic             gp_out_pin_b_oe,
   output logic [7:0]       pin_bias_enable,
   output logic             ref_enable,
   output logic             osc_enable,
   output logic             internal_regulator_on,
   output logic [3:0]       conv_mode,
   output logic             diag_clock_ok,
   output logic             ref_detect_enable,
   output logic             reg_cap_detect_enable,
   output logic             powered_down,
   output logic             settling
);

   // ============================================================
   // parameter check
   initial
   begin
      if (PD_WAKE_CYCLES < 1 || PD_WAKE_CYCLES > 65535 || OSC_WAKE_CYCLES < 1
          || OSC_WAKE_CYCLES > 1023)
         $error("adc_serial_port_power_ctrl: wake counts out of range");
   end

   // ============================================================
   // registers and state
   logic [15:0] core_mode_r;     // converter control word
   logic [23:0] gp_out_r;        // gp output enables and levels
   logic [15:0] bias_r;          // per-pin bias enables
   logic [23:0] data_r;          // conversion data word
   logic [23:0] conv_hold_r;     // word waiting to enter data_r
   logic        upd_pend_r;      // data_r update scheduled next cycle
   logic        rdy_n_r;         // not-ready flag
   pwr_state_t  pstate_r;        // power sequencing state
   logic [15:0] wait_cnt_r;      // sys clock wait counter
   logic [7:0]  mclk_cnt_r;      // master clock settle counter
   port_phase_t phase_r;         // serial phase
   logic [4:0]  bit_cnt_r;       // bits taken in this phase
   logic [4:0]  len_r;           // bits in current phase
   logic [5:0]  addr_r;          // addressed register
   logic [23:0] sh_in_r;         // receive shift register
   logic [23:0] sh_out_r;        // transmit shift register
   logic [6:0]  ones_cnt_r;      // consecutive ones on din
   logic        sclk_q;          // previous sclk sample
   logic        cs_q;            // previous cs_n sample
   logic        ext_q;           // previous external clock sample
   logic        osc_lvl_r;       // internal oscillator square wave
   logic [3:0]  div_cnt_r;       // power mode divider

   // ============================================================
   // decoded fields and events
   logic [1:0]  clk_sel;
   logic [3:0]  mode_f;
   power_mode_t pmode;
   logic        int_clk;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        cs_rise;
   logic        last_bit;
   logic [7:0]  cmd_byte;
   logic [23:0] wr_word;
   logic        sw_reset;
   logic        wr_pulse;
   logic        rd_done;
   logic        pd_enter;
   logic        clr_regs;
   logic        osc_half;
   logic        base_tick;
   logic        mclk_raw;
   logic [3:0]  div_val;
   logic        port_live;

   assign clk_sel   = core_mode_r[`CM_CLKSEL_LSB +: 2];
   assign mode_f    = core_mode_r[`CM_MODE_LSB +: 4];
   assign pmode     = power_mode_t'(core_mode_r[`CM_PMODE_LSB +: 2]);
   assign int_clk   = (clk_sel == `CLKSEL_INT) || (clk_sel == `CLKSEL_INT_OUT);
   assign sclk_rise = sclk && !sclk_q && !cs_n;
   assign sclk_fall = !sclk && sclk_q && !cs_n;
   assign cs_rise   = cs_n && !cs_q;
   assign last_bit  = sclk_rise && (bit_cnt_r + 5'd1 == len_r);
   assign cmd_byte  = {sh_in_r[6:0], din};
   assign wr_word   = {sh_in_r[22:0], din};
   assign port_live = (pstate_r != PS_PDOWN) && (pstate_r != PS_WAKE);
   assign wr_pulse  = last_bit && (phase_r == PH_WRITE) && port_live;
   assign rd_done   = last_bit && (phase_r == PH_READ) && (addr_r == `REG_DATA);
   assign sw_reset  = sclk_rise && din && (ones_cnt_r == 7'(`SWRESET_ONES - 1));
   assign pd_enter  = (pstate_r == PS_STANDBY) && (mode_f == `MODE_PDOWN);
   assign clr_regs  = srst || sw_reset || pd_enter;

   // ============================================================
   // register lengths and read values
   function automatic logic [4:0] reg_len(input logic [5:0] a);
      case (a)
         `REG_CORE_MODE, `REG_BIAS: reg_len = `LEN_HALF;
         `REG_DATA, `REG_GP_OUT:    reg_len = `LEN_WORD;
         default:                   reg_len = `LEN_BYTE;
      endcase
   endfunction

   // read value left-aligned so the msb always leaves first
   function automatic logic [23:0] read_word(input logic [5:0] a);
      case (a)
         `REG_STATUS:    read_word = {rdy_n_r, 7'h00, 16'h0000};
         `REG_CORE_MODE: read_word = {core_mode_r, 8'h00};
         `REG_DATA:      read_word = data_r;
         `REG_GP_OUT:    read_word = gp_out_r;
         `REG_BIAS:      read_word = {bias_r, 8'h00};
         default:        read_word = 24'h000000;
      endcase
   endfunction

   // ============================================================
   // pin sampling for edge detection
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         sclk_q <= 1'b1;
         cs_q   <= 1'b1;
         ext_q  <= 1'b0;
      end
      else
      begin
         sclk_q <= sclk;
         cs_q   <= cs_n;
         ext_q  <= ext_clk_in;
      end
   end

   // ============================================================
   // serial reset detector: counts ones framed by a low chip select
   always_ff @(posedge sys_clk)
   begin
      if (srst || cs_n || sw_reset)
         ones_cnt_r <= 7'h00;
      else if (sclk_rise)
         ones_cnt_r <= din ? ones_cnt_r + 7'h01 : 7'h00;
   end

   // ============================================================
   // serial port phases
   // cs tied low never produces cs_rise, so framing falls back on counts
   always_ff @(posedge sys_clk)
   begin
      if (srst || sw_reset || cs_n || !port_live)
      begin
         phase_r   <= PH_CMD;
         bit_cnt_r <= 5'd0;
         len_r     <= `LEN_BYTE;
      end
      else if (last_bit)
      begin
         bit_cnt_r <= 5'd0;
         if (phase_r == PH_CMD && !cmd_byte[`CMD_WEN_N_BIT])
         begin
            // command byte picks the direction and target
            len_r   <= reg_len(cmd_byte[5:0]);
            phase_r <= cmd_byte[`CMD_READ_BIT] ? PH_READ : PH_WRITE;
         end
         else
         begin
            // data phase over, or invalid command byte ignored
            len_r   <= `LEN_BYTE;
            phase_r <= PH_CMD;
         end
      end
      else if (sclk_rise)
         bit_cnt_r <= bit_cnt_r + 5'd1;
   end

   // shift registers and latched address
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         sh_in_r  <= 24'h000000;
         sh_out_r <= 24'h000000;
         addr_r   <= 6'h00;
      end
      else if (last_bit && phase_r == PH_CMD && !cmd_byte[`CMD_WEN_N_BIT])
      begin
         sh_in_r  <= 24'h000000;
         addr_r   <= cmd_byte[5:0];
         sh_out_r <= read_word(cmd_byte[5:0]);
      end
      else
      begin
         if (sclk_rise)
            sh_in_r <= wr_word;
         if (sclk_fall && phase_r == PH_READ)
            sh_out_r <= {sh_out_r[22:0], 1'b0};
      end
   end

   // output pin: read data during a read, otherwise the ready flag;
   // the ready level shows as soon as cs falls, the first data bit once the command byte ends
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         dout_rdy    <= 1'b1;
         dout_rdy_oe <= 1'b0;
      end
      else
      begin
         dout_rdy    <= (phase_r == PH_READ) ? sh_out_r[23] : rdy_n_r;
         dout_rdy_oe <= !cs_n && (pstate_r != PS_PDOWN);
      end
   end

   // ============================================================
   // configuration registers
   always_ff @(posedge sys_clk)
   begin
      if (clr_regs)
      begin
         core_mode_r <= `CORE_MODE_RST;
         gp_out_r    <= `GP_OUT_RST;
         bias_r      <= `BIAS_RST;
      end
      else if (wr_pulse)
      begin
         case (addr_r)
            `REG_CORE_MODE:
            begin
               // power-down request outside standby is refused
               if (wr_word[`CM_MODE_LSB +: 4] != `MODE_PDOWN || pstate_r == PS_STANDBY)
                  core_mode_r <= wr_word[15:0];
            end
            `REG_GP_OUT: gp_out_r <= wr_word;
            `REG_BIAS:   bias_r   <= wr_word[15:0];
            default:     ;
         endcase
      end
   end

   // ============================================================
   // conversion data and ready flag
   always_ff @(posedge sys_clk)
   begin
      if (clr_regs)
      begin
         data_r      <= `DATA_RST;
         conv_hold_r <= `DATA_RST;
         upd_pend_r  <= 1'b0;
         rdy_n_r     <= 1'b1;
      end
      else if (conv_valid && pstate_r == PS_ACTIVE)
      begin
         conv_hold_r <= conv_data;
         upd_pend_r  <= 1'b1;
         rdy_n_r     <= 1'b1;
      end
      else if (upd_pend_r)
      begin
         // new word wins over a read finishing in the same cycle
         data_r     <= conv_hold_r;
         upd_pend_r <= 1'b0;
         rdy_n_r    <= 1'b0;
      end
      else if (rd_done)
         rdy_n_r <= 1'b1;
   end

   // ============================================================
   // clock generation: oscillator, source select, power mode divider
   phase_tick_gen #(
      .INC (2 * `OSC_HZ / 100),
      .MOD (`SYS_CLK_HZ / 100)
   ) u_osc (
      .sys_clk (sys_clk),
      .srst    (srst),
      .en      (osc_enable),
      .tick    (osc_half)
   );

   // oscillator square wave from the half-period tick
   always_ff @(posedge sys_clk)
   begin
      if (srst || !osc_enable)
         osc_lvl_r <= 1'b0;
      else if (osc_half)
         osc_lvl_r <= !osc_lvl_r;
   end

   assign base_tick = int_clk ? (osc_half && !osc_lvl_r) : (ext_clk_in && !ext_q);

   always_comb
   begin
      unique case (pmode)
         PM_LOW:  div_val = `DIV_LOW;
         PM_MID:  div_val = `DIV_MID;
         default: div_val = `DIV_FULL;
      endcase
   end

   // divide the base clock by the power mode factor
   always_ff @(posedge sys_clk)
   begin
      if (srst || pstate_r == PS_PDOWN)
         div_cnt_r <= 4'h0;
      else if (base_tick)
         div_cnt_r <= (div_cnt_r + 4'h1 >= div_val) ? 4'h0 : div_cnt_r + 4'h1;
   end

   assign mclk_raw = base_tick && (div_cnt_r + 4'h1 >= div_val);

   // ============================================================
   // power sequencing
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         pstate_r   <= PS_ACTIVE;
         wait_cnt_r <= 16'h0000;
         mclk_cnt_r <= 8'h00;
      end
      else
      begin
         unique case (pstate_r)
            PS_ACTIVE:
               if (mode_f == `MODE_STANDBY)
                  pstate_r <= PS_STANDBY;
            PS_STANDBY:
               if (pd_enter)
                  pstate_r <= PS_PDOWN;
               else if (mode_f != `MODE_STANDBY)
               begin
                  // external clock selected waits OSC_WAKE_CYCLES first; the internal oscillator runs in standby and waits none
                  wait_cnt_r <= int_clk ? 16'h0000 : 16'(OSC_WAKE_CYCLES);
                  mclk_cnt_r <= 8'(`STANDBY_SETTLE_MCLK);
                  pstate_r   <= PS_SETTLE;
               end
            PS_SETTLE:
               if (wait_cnt_r != 16'h0000)
                  wait_cnt_r <= wait_cnt_r - 16'h0001;
               else if (mclk_cnt_r == 8'h00)
                  pstate_r <= PS_ACTIVE;
               else if (mclk_raw)
                  mclk_cnt_r <= mclk_cnt_r - 8'h01;
            PS_PDOWN:
               if (sw_reset)
               begin
                  wait_cnt_r <= 16'(PD_WAKE_CYCLES);
                  pstate_r   <= PS_WAKE;
               end
            PS_WAKE:
               if (wait_cnt_r == 16'h0000)
                  pstate_r <= PS_ACTIVE;
               else
                  wait_cnt_r <= wait_cnt_r - 16'h0001;
            default:
               pstate_r <= PS_ACTIVE;
         endcase
      end
   end

   // ============================================================
   // block enables and pins
   // oscillator runs when selected, standby included
   assign osc_enable            = (pstate_r != PS_PDOWN) && int_clk;
   assign clk_pin_out           = osc_lvl_r;
   assign clk_pin_oe            = osc_enable && (clk_sel == `CLKSEL_INT_OUT);
   assign mclk_tick             = mclk_raw && (pstate_r == PS_ACTIVE);
   assign gp_out_pin_a          = gp_out_r[`GP_DAT_A_BIT];
   assign gp_out_pin_b          = gp_out_r[`GP_DAT_B_BIT];
   assign gp_out_pin_a_oe       = gp_out_r[`GP_EN_A_BIT] && !powered_down;
   assign gp_out_pin_b_oe       = gp_out_r[`GP_EN_B_BIT] && !powered_down;
   assign pin_bias_enable       = {bias_r[15:14], bias_r[11:10], bias_r[5:4], bias_r[1:0]};
   assign ref_enable            = core_mode_r[`CM_REF_EN_BIT];
   assign internal_regulator_on = !powered_down;
   assign conv_mode             = mode_f;
   assign diag_clock_ok         = (pstate_r == PS_ACTIVE)
                                  && (mode_f == `MODE_CONT || mode_f == `MODE_IDLE);
   assign ref_detect_enable     = ref_enable && (pstate_r == PS_ACTIVE);
   assign reg_cap_detect_enable = (pstate_r == PS_ACTIVE);
   assign powered_down          = (pstate_r == PS_PDOWN);
   assign settling              = (pstate_r == PS_SETTLE) || (pstate_r == PS_WAKE);

endmodule

`default_nettype wire

// [core/adc_port_defines.svh]
// register offsets, field positions, reset values and timing counts of the serial port block
`ifndef ADC_PORT_DEFINES_SVH
`define ADC_PORT_DEFINES_SVH

// ============================================================
// register offsets (6-bit address carried by the command byte)
`define REG_STATUS        6'h00
`define REG_CORE_MODE     6'h01
`define REG_DATA          6'h02
`define REG_GP_OUT        6'h03
`define REG_BIAS          6'h04

// ============================================================
// register lengths in serial bits
`define LEN_BYTE          5'd8
`define LEN_HALF          5'd16
`define LEN_WORD          5'd24

// ============================================================
// reset values
`define CORE_MODE_RST     16'h0000
`define GP_OUT_RST        24'h000000
`define BIAS_RST          16'h0000
`define DATA_RST          24'h000000

// ============================================================
// command byte fields
`define CMD_WEN_N_BIT     7
`define CMD_READ_BIT      6

// ============================================================
// core_mode_control fields
`define CM_REF_EN_BIT     8
`define CM_PMODE_LSB      6
`define CM_MODE_LSB       2
`define CM_CLKSEL_LSB     0

// conversion mode codes
`define MODE_CONT         4'h0
`define MODE_STANDBY      4'h2
`define MODE_PDOWN        4'h3
`define MODE_IDLE         4'h4

// clock source codes
`define CLKSEL_INT        2'h0
`define CLKSEL_INT_OUT    2'h1

// ============================================================
// gp output register fields
`define GP_DAT_B_BIT      23
`define GP_DAT_A_BIT      22
`define GP_EN_B_BIT       19
`define GP_EN_A_BIT       18

// status register field
`define STAT_RDY_N_BIT    7

// ============================================================
// timing
`define SYS_CLK_HZ        25000000
`define OSC_HZ            614400
`define STANDBY_SETTLE_MCLK 130
`define OSC_WAKE_US       40
`define OSC_WAKE_CYC      ((`OSC_WAKE_US * `SYS_CLK_HZ) / 1000000)
`define PD_WAKE_MS        2
`define PD_WAKE_CYC       ((`PD_WAKE_MS * `SYS_CLK_HZ) / 1000)
`define SWRESET_ONES      64
`define DIV_FULL          4'd1
`define DIV_MID           4'd4
`define DIV_LOW           4'd8

`endif

// [core/adc_port_pkg.sv]
// types shared by the serial port and power control block
package adc_port_pkg;

   // power sequencing states, gray along active-standby-pdown-wake-active
   typedef enum logic [2:0] {
      PS_ACTIVE  = 3'b000,
      PS_STANDBY = 3'b001,
      PS_PDOWN   = 3'b011,
      PS_WAKE    = 3'b010,
      PS_SETTLE  = 3'b101
   } pwr_state_t;

   // serial port phase
   typedef enum logic [1:0] {
      PH_CMD   = 2'b00,
      PH_READ  = 2'b01,
      PH_WRITE = 2'b11
   } port_phase_t;

   // power mode field codes (code 3 behaves as full power)
   typedef enum logic [1:0] {
      PM_LOW  = 2'b00,
      PM_MID  = 2'b01,
      PM_FULL = 2'b10
   } power_mode_t;

endpackage

// [core/phase_tick_gen.sv]
// fractional phase accumulator producing an enable tick at INC/MOD of the clock rate
`timescale 1ns/1ps
`default_nettype none

module phase_tick_gen #(
   parameter int unsigned INC = 12288,
   parameter int unsigned MOD = 250000
) (
   input  wire logic sys_clk,
   input  wire logic srst,
   input  wire logic en,
   output logic      tick
);

   // ============================================================
   // parameter check
   initial
   begin
      if (INC == 0 || INC >= MOD || MOD >= (1 << 30))
         $error("phase_tick_gen: INC must be in 1..MOD-1 and MOD below 2^30");
   end

   logic [31:0] acc_r;   // phase accumulator, always below MOD

   // accumulate while enabled; the remainder keeps the long-run rate exact
   always_ff @(posedge sys_clk)
   begin
      if (srst || !en)
      begin
         acc_r <= 32'h00000000;
         tick  <= 1'b0;
      end
      else if (acc_r + INC >= MOD)
      begin
         acc_r <= acc_r + INC - MOD;
         tick  <= 1'b1;
      end
      else
      begin
         acc_r <= acc_r + INC;
         tick  <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// [tb/adc_port_asserts.sv]
// property checker for the serial port and power control block
`timescale 1ns/1ps
`default_nettype none

module adc_port_asserts (
   input wire logic       sys_clk,
   input wire logic       srst,
   input wire logic       cs_n,
   input wire logic       conv_valid,
   input wire logic       dout_rdy,
   input wire logic       dout_rdy_oe,
   input wire logic [3:0] conv_mode,
   input wire logic       gp_out_pin_a_oe,
   input wire logic       gp_out_pin_b_oe,
   input wire logic       internal_regulator_on,
   input wire logic       powered_down,
   input wire logic       settling,
   input wire logic       reg_cap_detect_enable,
   input wire logic       ref_detect_enable,
   input wire logic       diag_clock_ok,
   input wire logic       mclk_tick,
   input wire logic       clk_pin_oe,
   input wire logic       osc_enable
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   // ============================================================
   // new word while idle: flag goes high for a cycle, then low
   sequence s_new_word;
      conv_valid && cs_n && !settling && !powered_down && conv_mode != 4'h2;
   endsequence
   sequence s_flag_pulse;
      dout_rdy ##1 !dout_rdy;
   endsequence
   sequence s_wake_wait;
      settling [*8];
   endsequence
   chk_flag_update: assert property (s_new_word |-> ##2 s_flag_pulse)
      else $error("ready flag did not pulse around a word update");
   chk_pd_tristate: assert property (powered_down |-> !gp_out_pin_a_oe && !gp_out_pin_b_oe)
      else $error("gp pin driven in power-down");
   chk_regulator_off: assert property (internal_regulator_on == !powered_down)
      else $error("regulator state disagrees with power-down");
   chk_standby_detect: assert property (conv_mode == 4'h2 && $past(conv_mode) == 4'h2
      |-> !reg_cap_detect_enable && !ref_detect_enable)
      else $error("detection active in standby");
   chk_diag_modes: assert property (diag_clock_ok |-> conv_mode == 4'h0 || conv_mode == 4'h4)
      else $error("clocked diagnostics outside continuous or idle");
   chk_tick_gated: assert property (settling || powered_down |-> !mclk_tick)
      else $error("master tick while not active");
   chk_clk_share: assert property (clk_pin_oe |-> osc_enable && !powered_down)
      else $error("clock pin driven without oscillator");
   chk_cs_release: assert property (cs_n [*5] |-> !dout_rdy_oe)
      else $error("data pin driven while deselected");
   // wake wait runs at least eight cycles and ends within forty more
   chk_wake_settle: assert property ($fell(powered_down) && !$past(srst)
      |-> s_wake_wait ##[1:40] !settling)
      else $error("power-down wake wait out of bounds");
endmodule

`default_nettype wire

// [tb/spi_host_model.sv]
// host serial port model: mode 3 framing, sclk idles high
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
   input  wire logic sys_clk,
   input  wire logic dout_rdy,
   output logic      cs_n,
   output logic      sclk,
   output logic      din
);
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b1;
      din  = 1'b1;
   end
   task automatic wt(input int k);
      repeat (k) @(negedge sys_clk);
   endtask
   // msb first; 3 cycles per phase keeps both sclk phases above 2 cycles;
   // read bit taken at the end of the high phase, before the fall shifts it
   task automatic bits(input int n, input logic [23:0] w, output logic [23:0] r);
      r = '0;
      for (int i = n - 1; i >= 0; i--)
      begin
         r[i] = dout_rdy;
         sclk = 1'b0;
         din  = w[i];
         wt(3);
         sclk = 1'b1;
         wt(3);
      end
   endtask
   // command byte first, then the data phase, framed by chip select
   task automatic access(input logic [7:0] c, input int n, input logic [23:0] w,
                         output logic [23:0] r);
      cs_n = 1'b0;
      wt(2);
      bits(8, {16'h0, c}, r);
      bits(n, w, r);
      cs_n = 1'b1;
      din  = ~din; // released line does not keep its last level
      wt(3);
   endtask
   // sixty-four ones with chip select low
   task automatic reset64;
      logic [23:0] r;
      cs_n = 1'b0;
      repeat (4) bits(16, 24'hFFFF, r);
      cs_n = 1'b1;
      wt(3);
   endtask
endmodule

`default_nettype wire

// [tb/adc_serial_port_power_ctrl_test.sv]
// self-checking bench for the serial port and power control block
`timescale 1ns/1ps
`default_nettype none

module adc_serial_port_power_ctrl_test;
   import adc_port_pkg::*;
   logic        sys_clk, srst, cs_n, sclk, din, dout_rdy, dout_rdy_oe, conv_valid;
   logic        ext_clk_in, clk_pin_out, clk_pin_oe, mclk_tick, osc_enable, ref_enable;
   logic        gp_out_pin_a, gp_out_pin_a_oe, gp_out_pin_b, gp_out_pin_b_oe;
   logic        internal_regulator_on, diag_clock_ok, ref_detect_enable;
   logic        reg_cap_detect_enable, powered_down, settling;
   logic [23:0] conv_data, rd, w;
   logic [7:0]  pin_bias_enable;
   logic [3:0]  conv_mode;
   int          n_fail, comparisons, cnt;

   adc_serial_port_power_ctrl #(.PD_WAKE_CYCLES(20), .OSC_WAKE_CYCLES(5)) uut (.*);
   spi_host_model host (.sys_clk(sys_clk), .dout_rdy(dout_rdy), .cs_n(cs_n), .sclk(sclk),
                        .din(din));

   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // free-running external master clock, one rising edge every 8 cycles
   initial
   begin
      ext_clk_in = 1'b0;
      forever
      begin
         repeat (4) @(negedge sys_clk);
         ext_clk_in = ~ext_clk_in;
      end
   end
   // ============================================================
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input int n, input logic [23:0] d);
      host.access({2'b00, a}, n, d, rd);
   endtask
   task automatic rdr(input logic [5:0] a, input int n, input logic [23:0] exp);
      host.access({2'b01, a}, n, 24'h0, rd);
      check(rd, exp);
   endtask
   task automatic wait_settle;
      cnt = 0;
      while (settling && cnt < 20000)
      begin
         @(negedge sys_clk);
         cnt++;
      end
      check(24'(settling), 24'h0);
   endtask
   function automatic logic [7:0] bias_map(input logic [23:0] d);
      return {d[15], d[14], d[11], d[10], d[5], d[4], d[1], d[0]};
   endfunction
   // tick count over 8192 cycles: full /1, mid /4, low /8
   function automatic int ticks(input int pm);
      return int'(64'd8192 * 614400 / 25000000 / (pm == 2 ? 1 : (pm == 1 ? 4 : 8)));
   endfunction
   task automatic results;
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // watchdog: tests need about 40k cycles
   initial
   begin
      #(40 * 80000);
      n_fail++;
      results();
   end
   // ============================================================
   initial
   begin
      srst = 1'b1;
      conv_valid = 1'b0;
      conv_data = 24'h0;
      w = $urandom(21);
      repeat (6) @(negedge sys_clk);
      srst = 1'b0;
      @(negedge sys_clk);
      rdr(6'h01, 16, 24'h0);
      rdr(6'h04, 16, 24'h0);
      rdr(6'h07, 8, 24'h0);
      $display("test reset values done");
      repeat (4)
      begin
         w = $urandom;
         wr(6'h04, 16, w);
         check(24'(pin_bias_enable), 24'(bias_map(w)));
         rdr(6'h04, 16, {8'h0, w[15:0]});
         wr(6'h03, 24, w);
         check(24'({gp_out_pin_b_oe, gp_out_pin_a_oe}), 24'(w[19:18]));
         check(24'({gp_out_pin_b, gp_out_pin_a}), 24'(w[23:22]));
         wr(6'h01, 16, 24'h0000);
      end
      wr(6'h04, 8, 24'hFF); // partial frame
      host.access(8'h84, 16, 24'h0, rd); // bad command byte
      check(24'(pin_bias_enable), 24'(bias_map(w)));
      $display("test registers done");
      @(negedge sys_clk);
      conv_valid = 1'b1;
      conv_data = $urandom;
      @(negedge sys_clk);
      conv_valid = 1'b0;
      repeat (3) @(negedge sys_clk);
      check(24'(dout_rdy), 24'h0);
      rdr(6'h02, 24, conv_data);
      check(24'(dout_rdy), 24'h1);
      rdr(6'h02, 24, conv_data);
      rdr(6'h00, 8, 24'h80);
      $display("test conversion done");
      for (int pm = 0; pm < 3; pm++)
      begin
         wr(6'h01, 16, 24'((pm << 6) | 1));
         cnt = 0;
         repeat (8192) @(negedge sys_clk) cnt += int'(mclk_tick);
         check(24'(cnt >= ticks(pm) - 1 && cnt <= ticks(pm) + 1), 24'h1);
      end
      cnt = 0;
      repeat (1000) @(negedge sys_clk) cnt += int'(clk_pin_out);
      check(24'(cnt >= 450 && cnt <= 550), 24'h1);
      check(24'({clk_pin_oe, diag_clock_ok}), 24'h3);
      $display("test power modes done");
      wr(6'h01, 16, 24'h008D); // power-down from active
      check(24'(powered_down), 24'h0);
      rdr(6'h01, 16, 24'h0081);
      wr(6'h01, 16, 24'h0189);
      check(24'({reg_cap_detect_enable, ref_enable}), 24'h1);
      rdr(6'h04, 16, {8'h0, w[15:0]});
      wr(6'h01, 16, 24'h0081);
      wait_settle();
      check(24'(cnt >= 5200 && cnt <= 5400), 24'h1);
      wr(6'h01, 16, 24'h008A);
      wr(6'h01, 16, 24'h0082);
      wait_settle();
      check(24'(cnt >= 1020 && cnt <= 1060), 24'h1);
      $display("test standby exit done");
      wr(6'h01, 16, 24'h0089);
      wr(6'h01, 16, 24'h008D);
      check(24'({powered_down, internal_regulator_on, gp_out_pin_a_oe}), 24'h4);
      host.reset64();
      wait_settle();
      check(24'(powered_down), 24'h0);
      rdr(6'h04, 16, 24'h0);
      rdr(6'h01, 16, 24'h0);
      $display("test power-down done");
      results();
   end
endmodule

bind adc_serial_port_power_ctrl adc_port_asserts chk (.*);

`default_nettype wire
